// >>> logic/rca_core.sv
// Two-stage 8-bit core: fetch over the program bus, execute over the data bus.
module rca_core (
	// Clock and reset.
	input wire logic clk,
	input wire logic resetn,
	// Program bus.
	output logic [rca_pkg::PC_W-1:0] prog_addr,
	input wire logic [rca_pkg::IW-1:0] prog_data,
	// Data bus.
	output rca_pkg::rca_dbus_type dbus,
	input wire logic [rca_pkg::DW-1:0] data_rd_data,
	// Visibility of internal state.
	output logic [rca_pkg::DW-1:0] acc_out,
	output logic [rca_pkg::DW-1:0] status_out,
	output logic instr_tick
);
	import rca_pkg::*;

	rca_state_type s_q;
	rca_state_type s_d;
	logic tick;
	logic exec;
	logic [1:0] cls;
	logic [3:0] fop;
	logic dsel;
	logic [7:0] f_dir;
	logic [7:0] eff_addr;
	logic [7:0] opnd;
	logic [7:0] lit;
	logic [7:0] alu_res;
	logic [9:0] sum;
	logic alu_c;
	logic alu_hc;
	logic upd_z;
	logic upd_c;
	logic wr_w;
	logic wr_f;
	logic branch;
	logic skip;
	logic is_sub;
	logic is_add;
	logic [PC_W-1:0] target;

	////////////////////////////////////////////////////////////////////////
	// Adder with nibble carry, shared by add and subtract.
	function automatic logic [9:0] add_nib(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		return {lo[4], full};
	endfunction : add_nib

	////////////////////////////////////////////////////////////////////////
	// Decode of the instruction register and operand selection.
	assign tick = s_q.cnt == CNT_W'(INSTR_CLKS - 1);
	assign exec = tick & s_q.ir_valid;
	assign cls = s_q.ir[11:10];
	assign fop = s_q.ir[9:6];
	assign dsel = s_q.ir[D_BIT];
	assign lit = s_q.ir[7:0];
	assign f_dir = {3'b000, s_q.ir[4:0]};
	// Address zero stands for the register that the pointer selects.
	assign eff_addr = (f_dir == ADDR_INDF) ? s_q.fsr : f_dir;

	// Special registers answer from inside; all else comes from the bus.
	always_comb
	begin
		unique case (eff_addr)
			ADDR_INDF: opnd = 8'h00;
			ADDR_PCL: opnd = s_q.pc[7:0];
			ADDR_STATUS: opnd = s_q.status;
			ADDR_FSR: opnd = s_q.fsr;
			default: opnd = data_rd_data;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Arithmetic unit; the accumulator is always one side of two-operand ops.
	always_comb
	begin
		alu_res = opnd;
		alu_c = s_q.status[BIT_C];
		alu_hc = s_q.status[BIT_HC];
		sum = 10'h000;
		upd_z = 1'b0;
		upd_c = 1'b0;
		wr_w = 1'b0;
		wr_f = 1'b0;
		branch = 1'b0;
		skip = 1'b0;
		is_sub = 1'b0;
		is_add = 1'b0;
		target = s_q.pc;
		unique case (cls)
			CLS_FILE:
			begin
				wr_w = ~dsel;
				wr_f = dsel;
				upd_z = 1'b1;
				unique case (fop)
					OP_MOVWF:
					begin
						alu_res = s_q.w;
						wr_w = 1'b0;
						wr_f = 1'b1;
						upd_z = 1'b0;
					end
					OP_CLR: alu_res = 8'h00;
					OP_SUB:
					begin
						// Adding the complement plus one: carry out means no borrow.
						sum = add_nib(opnd, ~s_q.w, 1'b1);
						is_sub = 1'b1;
					end
					OP_DEC: alu_res = opnd - 8'h01;
					OP_IOR: alu_res = opnd | s_q.w;
					OP_AND: alu_res = opnd & s_q.w;
					OP_XOR: alu_res = opnd ^ s_q.w;
					OP_ADD:
					begin
						sum = add_nib(opnd, s_q.w, 1'b0);
						is_add = 1'b1;
					end
					OP_MOV: alu_res = opnd;
					OP_COM: alu_res = ~opnd;
					OP_INC: alu_res = opnd + 8'h01;
					OP_RRF:
					begin
						alu_res = {s_q.status[BIT_C], opnd[7:1]};
						alu_c = opnd[0];
						upd_c = 1'b1;
						upd_z = 1'b0;
					end
					OP_RLF:
					begin
						alu_res = {opnd[6:0], s_q.status[BIT_C]};
						alu_c = opnd[7];
						upd_c = 1'b1;
						upd_z = 1'b0;
					end
					OP_SWAP:
					begin
						alu_res = {opnd[3:0], opnd[7:4]};
						upd_z = 1'b0;
					end
					default:
					begin
						// Unused codes do nothing.
						wr_w = 1'b0;
						wr_f = 1'b0;
						upd_z = 1'b0;
					end
				endcase
				if (is_sub || is_add)
				begin
					alu_res = sum[7:0];
					alu_c = sum[8];
					alu_hc = sum[9];
					upd_c = 1'b1;
				end
			end
			CLS_LIT:
			begin
				wr_w = 1'b1;
				upd_z = 1'b1;
				unique case (s_q.ir[9:8])
					LOP_MOV:
					begin
						alu_res = lit;
						upd_z = 1'b0;
					end
					LOP_IOR: alu_res = lit | s_q.w;
					LOP_AND: alu_res = lit & s_q.w;
					LOP_XOR: alu_res = lit ^ s_q.w;
				endcase
			end
			CLS_GOTO:
			begin
				branch = 1'b1;
				target = s_q.ir[9:0];
			end
			CLS_SKIP:
				skip = opnd[s_q.ir[7:5]] == s_q.ir[SENSE_BIT];
		endcase
		// A write to the program counter low byte is a jump.
		if (wr_f && eff_addr == ADDR_PCL)
		begin
			branch = 1'b1;
			target = {s_q.pc[9:8], alu_res};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: fetch every instruction cycle, execute the held word.
	always_comb
	begin
		s_d = s_q;
		s_d.wr_en = 1'b0;
		s_d.cnt = tick ? '0 : s_q.cnt + CNT_W'(1);
		if (tick)
		begin
			// The fetched word is a whole instruction; no second word exists.
			s_d.ir = prog_data;
			s_d.ir_valid = 1'b1;
			s_d.pc = s_q.pc + PC_W'(1);
		end
		if (exec)
		begin
			if (wr_w)
				s_d.w = alu_res;
			if (wr_f)
			begin
				unique case (eff_addr)
					ADDR_INDF, ADDR_PCL: ;
					ADDR_STATUS: s_d.status = alu_res;
					ADDR_FSR: s_d.fsr = alu_res;
					default:
					begin
						// Posted one-cycle write; the next read is a cycle later.
						s_d.wr_en = 1'b1;
						s_d.wr_addr = eff_addr;
						s_d.wr_data = alu_res;
					end
				endcase
			end
			// Flag updates win over a plain write to the status register.
			if (upd_z)
				s_d.status[BIT_Z] = alu_res == 8'h00;
			if (upd_c)
				s_d.status[BIT_C] = alu_c;
			if (is_sub || is_add)
				s_d.status[BIT_HC] = alu_hc;
			// The prefetched word is dropped, costing one more cycle.
			if (branch)
			begin
				s_d.pc = target;
				s_d.ir_valid = 1'b0;
			end
			if (skip)
				s_d.ir_valid = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= '{cnt: '0, pc: PC_RST, ir: IR_RST, ir_valid: 1'b0,
				w: 8'h00, status: STATUS_RST, fsr: FSR_RST, wr_en: 1'b0,
				wr_addr: 8'h00, wr_data: 8'h00};
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs: the two buses are driven independently of each other.
	assign prog_addr = s_q.pc;
	assign dbus.rd_addr = eff_addr;
	assign dbus.wr_en = s_q.wr_en;
	assign dbus.wr_addr = s_q.wr_addr;
	assign dbus.wr_data = s_q.wr_data;
	assign acc_out = s_q.w;
	assign status_out = s_q.status;
	assign instr_tick = tick;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_cycle_length: assert property (
		tick |=> !tick [*8]) else $error("instruction cycle too short");
	a_fetch_word: assert property (
		tick |=> s_q.ir == $past(prog_data)
		&& s_q.ir_valid == !$past(exec && (branch || skip)))
		else $error("fetched word not captured");
	a_pc_step: assert property (
		exec && !branch |=> prog_addr == $past(prog_addr) + PC_W'(1))
		else $error("program counter did not step by one");
	a_branch_flush: assert property (
		exec && branch |=> !s_q.ir_valid && prog_addr == $past(target))
		else $error("branch did not flush prefetched word");
	a_zero_flag: assert property (
		exec && upd_z |=> status_out[BIT_Z] == ($past(alu_res) == 8'h00))
		else $error("zero flag wrong");
	a_sub_borrow: assert property (
		exec && is_sub |=> status_out[BIT_C] == ($past(opnd) >= $past(acc_out))
		&& status_out[BIT_HC] ==
		(($past(opnd) & 8'h0f) >= ($past(acc_out) & 8'h0f)))
		else $error("subtract borrow flags wrong");
	a_add_carry: assert property (
		exec && is_add |=> status_out[BIT_C] ==
		(({1'b0, $past(opnd)} + {1'b0, $past(acc_out)}) > 9'h0ff)
		&& status_out[BIT_HC] ==
		(({1'b0, $past(opnd[3:0])} + {1'b0, $past(acc_out[3:0])}) > 5'h0f))
		else $error("add carry wrong");
	a_acc_hidden: assert property (
		!(exec && wr_w) |=> $stable(acc_out)) else $error("accumulator changed");
	a_indirect_addr: assert property (
		exec && wr_f && f_dir == ADDR_INDF && s_q.fsr > ADDR_FSR
		|=> dbus.wr_en && dbus.wr_addr == $past(s_q.fsr))
		else $error("indirect write not sent to pointer address");
	a_skip_drop: assert property (
		exec && skip |=> !s_q.ir_valid
		&& prog_addr == $past(prog_addr) + PC_W'(1))
		else $error("skipped word was not dropped");
	a_bus_write: assert property (
		exec && wr_f && eff_addr > ADDR_FSR |=> dbus.wr_en
		&& dbus.wr_addr == $past(eff_addr) ##1 !dbus.wr_en)
		else $error("data write not posted for one cycle");

endmodule : rca_core

// >>> logic/rca_pkg.sv
// Constants, decode fields and carrier types of the small 8-bit core.
package rca_pkg;

	// Timing: one instruction cycle is a whole number of core clocks.
	localparam int CLK_PERIOD_NS = 8;
	localparam int INSTR_CYCLE_NS = 200;
	localparam int INSTR_CLKS =
		(INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 5;

	// Widths.
	localparam int PC_W = 10;
	localparam int IW = 12;
	localparam int DW = 8;

	// Special registers inside data space.
	localparam logic [7:0] ADDR_INDF = 8'h00;
	localparam logic [7:0] ADDR_PCL = 8'h02;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_FSR = 8'h04;

	// Status bit positions and reset values.
	localparam int BIT_C = 0;
	localparam int BIT_HC = 1;
	localparam int BIT_Z = 2;
	localparam logic [9:0] PC_RST = 10'h000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] FSR_RST = 8'h00;
	localparam logic [11:0] IR_RST = 12'h000;

	// Instruction classes in bits 11:10.
	localparam logic [1:0] CLS_FILE = 2'b00;
	localparam logic [1:0] CLS_LIT = 2'b01;
	localparam logic [1:0] CLS_GOTO = 2'b10;
	localparam logic [1:0] CLS_SKIP = 2'b11;

	// File operations in bits 9:6; bit 5 picks file (1) or accumulator (0).
	localparam logic [3:0] OP_MOVWF = 4'h0;
	localparam logic [3:0] OP_CLR = 4'h1;
	localparam logic [3:0] OP_SUB = 4'h2;
	localparam logic [3:0] OP_DEC = 4'h3;
	localparam logic [3:0] OP_IOR = 4'h4;
	localparam logic [3:0] OP_AND = 4'h5;
	localparam logic [3:0] OP_XOR = 4'h6;
	localparam logic [3:0] OP_ADD = 4'h7;
	localparam logic [3:0] OP_MOV = 4'h8;
	localparam logic [3:0] OP_COM = 4'h9;
	localparam logic [3:0] OP_INC = 4'ha;
	localparam logic [3:0] OP_RRF = 4'hb;
	localparam logic [3:0] OP_RLF = 4'hc;
	localparam logic [3:0] OP_SWAP = 4'hd;

	// Literal operations in bits 9:8.
	localparam logic [1:0] LOP_MOV = 2'b00;
	localparam logic [1:0] LOP_IOR = 2'b01;
	localparam logic [1:0] LOP_AND = 2'b10;
	localparam logic [1:0] LOP_XOR = 2'b11;

	// Field positions.
	localparam int D_BIT = 5;
	localparam int SENSE_BIT = 9;

	// Data bus request, all fields from flip-flops except the read address.
	typedef struct packed {
		logic [7:0] rd_addr;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} rca_dbus_type;

	// Whole state of the core.
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [PC_W-1:0] pc;
		logic [IW-1:0] ir;
		logic ir_valid;
		logic [7:0] w;
		logic [7:0] status;
		logic [7:0] fsr;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
	} rca_state_type;

endpackage : rca_pkg

// >>> testbench/rca_mem_model.sv
// Behavioural program memory and data RAM on the far side of the core.
module rca_mem_model (
	// Clock.
	input wire logic clk,
	// Program bus.
	input wire logic [rca_pkg::PC_W-1:0] prog_addr,
	output logic [rca_pkg::IW-1:0] prog_data,
	// Data bus.
	input wire rca_pkg::rca_dbus_type dbus,
	output logic [rca_pkg::DW-1:0] data_rd_data
);
	timeunit 1ns;
	timeprecision 100ps;
	import rca_pkg::*;

	logic [IW-1:0] rom [0:1023];
	logic [DW-1:0] ram [0:255];

	// Both reads are asynchronous, so the core sees them in the same cycle.
	assign prog_data = rom[prog_addr];
	assign data_rd_data = ram[dbus.rd_addr];

	// A write lands at the edge that ends the one-cycle pulse.
	always @(posedge clk)
	begin
		if (dbus.wr_en)
			ram[dbus.wr_addr] <= dbus.wr_data;
	end
endmodule : rca_mem_model

// >>> testbench/tb_top.sv
// Self-checking bench: a random program runs on the core beside a reference.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rca_pkg::*;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [PC_W-1:0] prog_addr;
	logic [IW-1:0] prog_data;
	rca_dbus_type dbus;
	logic [DW-1:0] data_rd_data;
	logic [DW-1:0] acc_out;
	logic [DW-1:0] status_out;
	logic instr_tick;
	int n_errors = 0;
	int checked = 0;
	int seed = 15841;
	int n;
	logic [31:0] r;
	logic [IW-1:0] prog [0:1023];
	logic [7:0] mram [0:255];
	logic [7:0] e_acc, e_st, e_fsr, e_wa, e_wd;
	logic [PC_W-1:0] e_pc;
	logic [IW-1:0] e_ir;
	logic e_irv, e_wr;

	// The clock period is 8 ns.
	always #4 clk = ~clk;

	rca_core u_rca_core (.clk(clk), .resetn(resetn), .prog_addr(prog_addr),
		.prog_data(prog_data), .dbus(dbus), .data_rd_data(data_rd_data),
		.acc_out(acc_out), .status_out(status_out), .instr_tick(instr_tick));
	rca_mem_model u_mem (.clk(clk), .prog_addr(prog_addr),
		.prog_data(prog_data), .dbus(dbus), .data_rd_data(data_rd_data));

	//////////////////////////////////////////////////////////////////////////
	// Verdict and comparisons; case inequality keeps unknowns from passing.
	task automatic stop_test();
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic chk_byte(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte

	task automatic chk_addr(input string nm, input logic [PC_W-1:0] e,
		input logic [PC_W-1:0] g);
		chk_byte(nm, e[7:0], g[7:0]);
		chk_byte(nm, {6'h00, e[9:8]}, {6'h00, g[9:8]});
	endtask : chk_addr

	// Reference arithmetic: returns result, carry and half carry.
	function automatic logic [9:0] alu(input logic [3:0] op,
		input logic [7:0] f, input logic [7:0] w, input logic c);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, f} + {1'b0, w};
		h = {1'b0, f[3:0]} + {1'b0, w[3:0]};
		case (op)
			OP_MOVWF: return {w, c, 1'b0};
			OP_CLR: return {8'h00, c, 1'b0};
			OP_SUB:
			begin
				// Borrow shows as a cleared carry.
				s = {1'b0, f} + {1'b0, ~w} + 9'h001;
				h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				return {s[7:0], s[8], h[4]};
			end
			OP_ADD: return {s[7:0], s[8], h[4]};
			OP_DEC: return {f - 8'h01, c, 1'b0};
			OP_IOR: return {f | w, c, 1'b0};
			OP_AND: return {f & w, c, 1'b0};
			OP_XOR: return {f ^ w, c, 1'b0};
			OP_COM: return {~f, c, 1'b0};
			OP_INC: return {f + 8'h01, c, 1'b0};
			OP_RRF: return {c, f[7:1], f[0], 1'b0};
			OP_RLF: return {f[6:0], c, f[7], 1'b0};
			OP_SWAP: return {f[3:0], f[7:4], c, 1'b0};
			default: return {f, c, 1'b0};
		endcase
	endfunction : alu

	// Reference for one instruction cycle: execute, then fetch.
	task automatic ref_tick();
		logic lit, jmp, skp, wf;
		logic [3:0] op;
		logic [7:0] ea, fv, res;
		logic [9:0] a;
		logic [PC_W-1:0] tgt;
		e_wr = 1'b0;
		lit = e_ir[11:10] == CLS_LIT;
		// Literal ops 1..3 map onto the file ior, and, xor codes.
		op = !lit ? e_ir[9:6] : e_ir[9:8] == LOP_MOV ? OP_MOV :
			4'(3 + e_ir[9:8]);
		ea = e_ir[4:0] == 5'h00 ? e_fsr : {3'b000, e_ir[4:0]};
		// Special registers answer from inside the core, not from the RAM.
		fv = ea == ADDR_INDF ? 8'h00 : ea == ADDR_PCL ? e_pc[7:0] :
			ea == ADDR_STATUS ? e_st : ea == ADDR_FSR ? e_fsr : mram[ea];
		a = alu(op, lit ? e_ir[7:0] : fv, e_acc, e_st[BIT_C]);
		res = a[9:2];
		jmp = e_irv && e_ir[11:10] == CLS_GOTO;
		skp = e_irv && e_ir[11:10] == CLS_SKIP;
		skp = skp && fv[e_ir[7:5]] == e_ir[SENSE_BIT];
		tgt = e_ir[9:0];
		wf = !lit && op < 4'he && (e_ir[D_BIT] || op == OP_MOVWF);
		if (e_irv && !e_ir[11])
		begin
			// The destination is written first; flags then take precedence.
			if (lit || (!wf && op < 4'he))
				e_acc = res;
			else if (wf && ea == ADDR_PCL)
			begin
				jmp = 1'b1;
				tgt = {e_pc[9:8], res};
			end
			else if (wf && ea == ADDR_STATUS)
				e_st = res;
			else if (wf && ea == ADDR_FSR)
				e_fsr = res;
			else if (wf && ea != ADDR_INDF)
			begin
				e_wr = 1'b1;
				e_wa = ea;
				e_wd = res;
				mram[ea] = res;
			end
			if (op inside {OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR,
				OP_ADD, OP_MOV, OP_COM, OP_INC} && !(lit && op == OP_MOV))
				e_st[BIT_Z] = res == 8'h00;
			if (!lit && op inside {OP_ADD, OP_SUB, OP_RRF, OP_RLF})
				e_st[BIT_C] = a[1];
			if (!lit && op inside {OP_ADD, OP_SUB})
				e_st[BIT_HC] = a[0];
		end
		// A flow change drops the word fetched in its own cycle.
		e_irv = !(jmp || skp);
		e_ir = prog[e_pc];
		e_pc = jmp ? tgt : e_pc + 10'h001;
	endtask : ref_tick

	//////////////////////////////////////////////////////////////////////////
	// Program: hand-written corner cases, then random words with jumps.
	initial
	begin
		for (int i = 0; i < 256; i++)
			mram[i] = 8'($random(seed));
		mram[8'h10] = 8'h01;
		mram[8'h11] = 8'h00;
		for (int i = 0; i < 1024; i++)
			prog[i] = {CLS_FILE, 4'he, 6'h00};
		prog[0] = {CLS_LIT, LOP_MOV, 8'h15};
		prog[1] = {CLS_FILE, OP_MOVWF, 1'b1, 5'h04};
		prog[2] = {CLS_LIT, LOP_MOV, 8'hff};
		prog[3] = {CLS_FILE, OP_ADD, 1'b0, 5'h10};
		prog[4] = {CLS_LIT, LOP_IOR, 8'h01};
		prog[5] = {CLS_FILE, OP_SUB, 1'b1, 5'h11};
		prog[6] = {CLS_GOTO, 10'h008};
		prog[7] = {CLS_LIT, LOP_MOV, 8'h5a};
		// Counter low byte read, taken and untaken skips, a jump made by
		// writing the counter, a status write and an indirect read.
		prog[8] = {CLS_FILE, OP_MOV, 1'b0, 5'h02};
		prog[9] = {CLS_SKIP, 1'b0, 1'b0, 3'h2, 5'h03};
		prog[10] = {CLS_LIT, LOP_MOV, 8'hee};
		prog[11] = {CLS_SKIP, 1'b1, 1'b0, 3'h2, 5'h03};
		prog[12] = {CLS_LIT, LOP_MOV, 8'h10};
		prog[13] = {CLS_FILE, OP_MOVWF, 1'b1, 5'h02};
		prog[14] = {CLS_LIT, LOP_MOV, 8'h77};
		prog[16] = {CLS_FILE, OP_COM, 1'b1, 5'h03};
		prog[17] = {CLS_FILE, OP_MOV, 1'b0, 5'h00};
		for (int i = 18; i < 200; i++)
		begin
			r = $random(seed);
			if (r[15:12] == 4'h0)
				prog[i] = {CLS_GOTO, 10'(i + 2)};
			else if (r[15:12] == 4'h1)
				prog[i] = {CLS_SKIP, r[9:8], r[4:2], 1'b1, r[10:7]};
			else if (r[1:0] == 2'b00)
				prog[i] = {CLS_LIT, r[9:8], r[7:0]};
			else
				prog[i] = {CLS_FILE, r[5:2], r[11] | (r[5:2] == OP_MOVWF),
					r[6] ? 5'h00 : {1'b1, r[10:7]}};
		end
		for (int i = 0; i < 1024; i++)
			u_mem.rom[i] = prog[i];
		for (int i = 0; i < 256; i++)
			u_mem.ram[i] = mram[i];
		{e_acc, e_st, e_fsr, e_pc, e_irv} = '0;
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (210)
		begin
			n = 0;
			do
			begin
				@(negedge clk);
				n++;
			end
			while (instr_tick !== 1'b1 && n < 40);
			if (n >= 40)
			begin
				n_errors++;
				stop_test();
			end
			@(posedge clk);
			#1 ref_tick();
			chk_byte("tick_gap", 8'(INSTR_CLKS), 8'(n));
			chk_byte("acc", e_acc, acc_out);
			chk_byte("status", e_st, status_out);
			chk_addr("prog_addr", e_pc, prog_addr);
			chk_byte("rd_addr", e_ir[4:0] == 5'h00 ? e_fsr :
				{3'b000, e_ir[4:0]}, dbus.rd_addr);
			chk_byte("wr_en", {7'h00, e_wr}, {7'h00, dbus.wr_en});
			if (e_wr)
			begin
				chk_byte("wr_addr", e_wa, dbus.wr_addr);
				chk_byte("wr_data", e_wd, dbus.wr_data);
			end
		end
		stop_test();
	end
endmodule : tb_top
